// ===== design/mts_regs.vh
`ifndef MTS_REGS_VH
`define MTS_REGS_VH
// Register offsets (byte addresses)
`define MTS_OFS_INSTR 8'h00
`define MTS_OFS_PROG_COUNTER 8'h04
`define MTS_OFS_STATUS 8'h08
`define MTS_OFS_CUR_STATUS 8'h0c
`define MTS_OFS_SAVED_STATUS 8'h10
`define MTS_OFS_REG_INDEX 8'h14
`define MTS_OFS_REG_DATA 8'h18
// Reset values
`define MTS_RST_CUR_STATUS 32'h0000_00d3
`define MTS_RST_PC 32'h0000_0000
// Instruction field positions
`define MTS_F_COND_HI 31
`define MTS_F_COND_LO 28
`define MTS_F_P 24
`define MTS_F_U 23
`define MTS_F_S 22
`define MTS_F_W 21
`define MTS_F_L 20
`define MTS_F_BASE_HI 19
`define MTS_F_BASE_LO 16
`define MTS_F_RD_HI 15
`define MTS_F_RD_LO 12
// Status word fields
`define MTS_MODE_USER 5'h10
// Address arithmetic constants
`define MTS_PC_AHEAD 32'h0000_0008
`define MTS_WORD_STEP 32'h0000_0004
// Memory access sizes
`define MTS_SZ_BYTE 2'b00
`define MTS_SZ_HALF 2'b01
`define MTS_SZ_WORD 2'b10
`endif

// ===== design/mts_regfile.v
`default_nettype none
// ==========================================
// General register store with registered read
module mts_regfile #(
	parameter ADDR_W = 5,
	parameter DATA_W = 32
) (
	// Clock and reset
	input wire clk_sys_in,
	input wire resetn_in,
	// Write port
	input wire we_in,
	input wire [ADDR_W-1:0] waddr_in,
	input wire [DATA_W-1:0] wdata_in,
	// Read port
	input wire [ADDR_W-1:0] raddr_in,
	output reg [DATA_W-1:0] rdata_out
);
	reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	// Write; the array itself has no reset, software loads it
	always @(posedge clk_sys_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
	end

	// Read data one cycle after the address; old data on a same-cycle write
	always @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			rdata_out <= {DATA_W{1'b0}};
		end else begin
			rdata_out <= mem[raddr_in];
		end
	end
endmodule // mts_regfile
`default_nettype wire

// ===== design/mts_exec.v
`include "mts_regs.vh"
`default_nettype none
module mts_exec (
	// Clock and reset
	input wire clk_sys_in,
	input wire resetn_in,
	// AHB-Lite slave
	input wire hsel_in,
	input wire [7:0] haddr_in,
	input wire [1:0] htrans_in,
	input wire hwrite_in,
	input wire [2:0] hsize_in,
	input wire [31:0] hwdata_in,
	input wire hready_in,
	output wire hreadyout_out,
	output wire [31:0] hrdata_out,
	output wire hresp_out,
	// Memory system
	output reg mem_req_out,
	output reg [31:0] mem_addr_out,
	output reg mem_write_out,
	output reg [1:0] mem_size_out,
	output reg [31:0] mem_wdata_out,
	output reg mem_user_out,
	output reg mem_lock_out,
	input wire mem_ack_in,
	input wire [31:0] mem_rdata_in,
	// Exception logic
	input wire debug_override_in,
	output reg call_trap_out,
	output reg prefetch_abort_out,
	output reg debug_break_out
);
	// ==========================================
	// States
	localparam [7:0] ST_IDLE = 8'h01;
	localparam [7:0] ST_RDA = 8'h02;
	localparam [7:0] ST_RDB = 8'h04;
	localparam [7:0] ST_CALC = 8'h08;
	localparam [7:0] ST_PREP = 8'h10;
	localparam [7:0] ST_ISSUE = 8'h20;
	localparam [7:0] ST_WAIT = 8'h40;
	localparam [7:0] ST_WB = 8'h80;

	// ==========================================
	// Functions
	function cond_pass(input [3:0] c, input [3:0] f);
		reg n, z, cy, v;
		begin
			n = f[3];
			z = f[2];
			cy = f[1];
			v = f[0];
			case (c)
				4'h0: cond_pass = z;
				4'h1: cond_pass = !z;
				4'h2: cond_pass = cy;
				4'h3: cond_pass = !cy;
				4'h4: cond_pass = n;
				4'h5: cond_pass = !n;
				4'h6: cond_pass = v;
				4'h7: cond_pass = !v;
				4'h8: cond_pass = cy && !z;
				4'h9: cond_pass = !cy || z;
				4'ha: cond_pass = (n == v);
				4'hb: cond_pass = (n != v);
				4'hc: cond_pass = !z && (n == v);
				4'hd: cond_pass = z || (n != v);
				default: cond_pass = 1'b1;
			endcase
		end
	endfunction

	// Banked copies exist for registers 8..14 only
	function [4:0] rf_index(input [3:0] r, input ub);
		begin
			rf_index = {ub && (r >= 4'h8) && (r <= 4'he), r};
		end
	endfunction

	function [4:0] popcount16(input [15:0] m);
		integer i;
		begin
			popcount16 = 5'h00;
			for (i = 0; i < 16; i = i + 1) begin
				popcount16 = popcount16 + {4'h0, m[i]};
			end
		end
	endfunction

	function [3:0] lowest_set(input [15:0] m);
		integer i;
		begin
			lowest_set = 4'h0;
			for (i = 15; i >= 0; i = i - 1) begin
				if (m[i]) begin
					lowest_set = i[3:0];
				end
			end
		end
	endfunction

	function [31:0] fmt_load(input [31:0] d, input [1:0] a, input [1:0] sz, input sgn);
		reg [7:0] b;
		reg [15:0] h;
		begin
			b = d[{a, 3'b000} +: 8];
			h = a[1] ? d[31:16] : d[15:0];
			if (sz == `MTS_SZ_BYTE) begin
				fmt_load = sgn ? {{24{b[7]}}, b} : {24'h000000, b};
			end else if (sz == `MTS_SZ_HALF) begin
				fmt_load = sgn ? {{16{h[15]}}, h} : {16'h0000, h};
			end else begin
				fmt_load = d;
			end
		end
	endfunction

	// ==========================================
	// State
	reg [7:0] state;
	reg [31:0] instr, pc, csw, ssw, base, addr, wb_val, swap_data, load_hold;
	reg [4:0] reg_index;
	reg [15:0] mask_left;
	reg [3:0] beat_reg;
	reg go, beat, wb_en, user_bank, pc_loaded;
	reg st_call, st_pabort, st_dbg, st_undef, st_cfail;
	reg dp_valid, dp_write, rd_wait;
	reg [7:0] dp_addr;
	reg [31:0] rd_mux;
	reg [31:0] rd_word;
	reg [4:0] rf_raddr, rf_waddr;
	reg [31:0] rf_wdata;
	reg rf_we;
	wire [31:0] rf_rdata;

	// ==========================================
	// Decode
	wire [3:0] f_base = instr[`MTS_F_BASE_HI:`MTS_F_BASE_LO];
	wire [3:0] f_rd = instr[`MTS_F_RD_HI:`MTS_F_RD_LO];
	wire [3:0] f_rm = instr[3:0];
	wire [1:0] f_sh = instr[6:5];
	wire f_p = instr[`MTS_F_P];
	wire f_u = instr[`MTS_F_U];
	wire f_s = instr[`MTS_F_S];
	wire f_w = instr[`MTS_F_W];
	wire f_l = instr[`MTS_F_L];
	wire is_brk = (instr[27:20] == 8'h12) && (instr[7:4] == 4'h7);
	wire is_call = (instr[27:24] == 4'hf);
	wire is_swap = (instr[27:23] == 5'b00010) && (instr[21:20] == 2'b00) && (instr[11:4] == 8'h09);
	wire is_misc = (instr[27:25] == 3'b000) && instr[7] && instr[4] && (f_sh != 2'b00);
	wire is_single = (instr[27:26] == 2'b01);
	wire is_multi = (instr[27:25] == 3'b100);
	wire misc_dword = is_misc && !f_l && f_sh[1];
	wire do_load = (is_misc && misc_dword) ? !f_sh[0] : f_l;
	wire acc_load = is_swap ? !beat : do_load;
	wire privileged = (csw[4:0] != `MTS_MODE_USER);
	wire use_rm = (is_single && instr[25]) || (is_misc && !f_s) || is_swap;
	wire [31:0] imm = is_single ? {20'h00000, instr[11:0]} : {24'h000000, instr[11:8], instr[3:0]};
	wire [31:0] ofs_v = use_rm ? rf_rdata : imm;
	wire [31:0] calc = f_u ? base + ofs_v : base - ofs_v;
	wire [31:0] n4 = {25'h0000000, popcount16(instr[15:0]), 2'b00};
	wire [15:0] next_mask = mask_left & ~(16'h0001 << beat_reg);
	wire [31:0] pc_ahead = pc + `MTS_PC_AHEAD;
	wire base_loaded = is_multi ? instr[f_base] : ((f_rd == f_base) || (misc_dword && ((f_rd | 4'h1) == f_base)));
	wire busy = (state != ST_IDLE) || go;
	wire is_lsb = (is_misc && f_l && (f_sh == 2'b10)) || ((is_single || is_swap) && f_s);
	wire sgn = is_misc && f_l && f_sh[1];
	wire [1:0] size = is_lsb || (!is_misc && !is_multi && f_s) ? `MTS_SZ_BYTE :
		(is_misc && !misc_dword) ? `MTS_SZ_HALF : `MTS_SZ_WORD;
	wire [31:0] store_v = is_swap ? swap_data : (beat_reg == 4'hf) ? pc_ahead : rf_rdata;
	wire [31:0] ld_v = fmt_load(mem_rdata_in, addr[1:0], size, sgn);
	wire last_beat = !(is_swap && !beat) && !(misc_dword && !beat) && !(is_multi && (next_mask != 16'h0000));
	wire wb_write = is_swap ? (f_rd != 4'hf) : (wb_en && (f_base != 4'hf) && !(do_load && base_loaded));

	// ==========================================
	// AHB-Lite slave; reads take one wait state so register file data settle
	wire ahb_take = hsel_in && htrans_in[1] && hready_in;
	wire ahb_wfire = dp_valid && dp_write;
	assign hreadyout_out = !(dp_valid && !dp_write && !rd_wait);
	assign hresp_out = 1'b0;
	assign hrdata_out = rd_word;

	always @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
			rd_wait <= 1'b0;
			rd_word <= 32'h00000000;
		end else begin
			if (ahb_take) begin
				dp_valid <= 1'b1;
				dp_write <= hwrite_in;
				dp_addr <= haddr_in;
			end else if (hreadyout_out) begin
				dp_valid <= 1'b0;
			end
			rd_wait <= dp_valid && !dp_write && !rd_wait;
			// Captured in the wait state so the bus sees a flop, not the mux
			rd_word <= (dp_valid && !dp_write && !rd_wait) ? rd_mux : 32'h00000000;
		end
	end

	// Read mux; unmapped offsets read zero
	always @* begin
		if (dp_addr == `MTS_OFS_INSTR) begin
			rd_mux = instr;
		end else if (dp_addr == `MTS_OFS_PROG_COUNTER) begin
			rd_mux = pc;
		end else if (dp_addr == `MTS_OFS_STATUS) begin
			rd_mux = {26'h0000000, st_cfail, st_undef, st_dbg, st_pabort, st_call, busy};
		end else if (dp_addr == `MTS_OFS_CUR_STATUS) begin
			rd_mux = csw;
		end else if (dp_addr == `MTS_OFS_SAVED_STATUS) begin
			rd_mux = ssw;
		end else if (dp_addr == `MTS_OFS_REG_INDEX) begin
			rd_mux = {27'h0000000, reg_index};
		end else if (dp_addr == `MTS_OFS_REG_DATA) begin
			rd_mux = rf_rdata;
		end else begin
			rd_mux = 32'h00000000;
		end
	end

	// ==========================================
	// Register file ports
	always @* begin
		case (state)
			ST_RDA: rf_raddr = rf_index(f_base, 1'b0);
			ST_RDB: rf_raddr = rf_index(f_rm, 1'b0);
			ST_PREP: rf_raddr = rf_index(beat_reg, user_bank);
			default: rf_raddr = reg_index;
		endcase
	end

	// One write port: load data, base update, or software while idle
	always @* begin
		rf_we = 1'b0;
		rf_waddr = reg_index;
		rf_wdata = hwdata_in;
		if ((state == ST_WAIT) && mem_ack_in && acc_load && !is_swap && (beat_reg != 4'hf)) begin
			rf_we = 1'b1;
			rf_waddr = rf_index(beat_reg, user_bank);
			rf_wdata = ld_v;
		end else if ((state == ST_WB) && wb_write) begin
			rf_we = 1'b1;
			rf_waddr = is_swap ? rf_index(f_rd, 1'b0) : rf_index(f_base, 1'b0);
			rf_wdata = is_swap ? load_hold : wb_val;
		end else if (!busy && ahb_wfire && (dp_addr == `MTS_OFS_REG_DATA)) begin
			rf_we = 1'b1;
		end
	end

	mts_regfile #(.ADDR_W(5), .DATA_W(32)) u_regfile (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.we_in(rf_we),
		.waddr_in(rf_waddr),
		.wdata_in(rf_wdata),
		.raddr_in(rf_raddr),
		.rdata_out(rf_rdata)
	);

	// ==========================================
	// Sequencer, program state and software registers
	always @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			state <= ST_IDLE;
			instr <= 32'h00000000;
			pc <= `MTS_RST_PC;
			csw <= `MTS_RST_CUR_STATUS;
			ssw <= 32'h00000000;
			reg_index <= 5'h00;
			go <= 1'b0;
			base <= 32'h00000000;
			addr <= 32'h00000000;
			wb_val <= 32'h00000000;
			swap_data <= 32'h00000000;
			load_hold <= 32'h00000000;
			mask_left <= 16'h0000;
			beat_reg <= 4'h0;
			beat <= 1'b0;
			wb_en <= 1'b0;
			user_bank <= 1'b0;
			pc_loaded <= 1'b0;
			{st_call, st_pabort, st_dbg, st_undef, st_cfail} <= 5'h00;
			mem_req_out <= 1'b0;
			mem_addr_out <= 32'h00000000;
			mem_write_out <= 1'b0;
			mem_size_out <= `MTS_SZ_WORD;
			mem_wdata_out <= 32'h00000000;
			mem_user_out <= 1'b0;
			mem_lock_out <= 1'b0;
			call_trap_out <= 1'b0;
			prefetch_abort_out <= 1'b0;
			debug_break_out <= 1'b0;
		end else begin
			call_trap_out <= 1'b0;
			prefetch_abort_out <= 1'b0;
			debug_break_out <= 1'b0;
			// Software writes; execution state is locked while busy
			if (ahb_wfire && (dp_addr == `MTS_OFS_REG_INDEX)) begin
				reg_index <= hwdata_in[4:0];
			end
			if (ahb_wfire && !busy) begin
				if (dp_addr == `MTS_OFS_INSTR) begin
					instr <= hwdata_in;
					go <= 1'b1;
				end else if (dp_addr == `MTS_OFS_PROG_COUNTER) begin
					pc <= hwdata_in;
				end else if (dp_addr == `MTS_OFS_CUR_STATUS) begin
					csw <= hwdata_in;
				end else if (dp_addr == `MTS_OFS_SAVED_STATUS) begin
					ssw <= hwdata_in;
				end
			end
			case (state)
				ST_IDLE: begin
					if (go) begin
						go <= 1'b0;
						pc_loaded <= 1'b0;
						{st_call, st_pabort, st_dbg, st_undef, st_cfail} <= 5'h00;
						// Trap immediates are never looked at
						if (is_brk) begin
							debug_break_out <= debug_override_in;
							st_dbg <= debug_override_in;
							prefetch_abort_out <= !debug_override_in;
							st_pabort <= !debug_override_in;
						end else if (!cond_pass(instr[`MTS_F_COND_HI:`MTS_F_COND_LO], csw[31:28])) begin
							st_cfail <= 1'b1;
							pc <= pc + `MTS_WORD_STEP;
						end else if (is_call) begin
							call_trap_out <= 1'b1;
							st_call <= 1'b1;
						end else if (is_swap || is_misc || is_single || is_multi) begin
							state <= ST_RDA;
						end else begin
							st_undef <= 1'b1;
						end
					end
				end
				ST_RDA: begin
					state <= ST_RDB;
				end
				ST_RDB: begin
					base <= (f_base == 4'hf) ? pc_ahead : rf_rdata;
					state <= ST_CALC;
				end
				ST_CALC: begin
					beat <= 1'b0;
					mask_left <= instr[15:0];
					beat_reg <= is_multi ? lowest_set(instr[15:0]) : f_rd;
					mem_user_out <= is_single && !f_p && f_w;
					user_bank <= is_multi && f_s && !(f_l && instr[15]) && privileged;
					if (is_swap) begin
						addr <= base;
						swap_data <= rf_rdata;
						wb_en <= 1'b0;
						mem_lock_out <= 1'b1;
						state <= ST_PREP;
					end else if (is_multi) begin
						// Start address and final base per mode
						if (f_u) begin
							addr <= f_p ? base + `MTS_WORD_STEP : base;
							wb_val <= base + n4;
						end else begin
							addr <= f_p ? base - n4 : base - n4 + `MTS_WORD_STEP;
							wb_val <= base - n4;
						end
						wb_en <= f_w;
						state <= (instr[15:0] == 16'h0000) ? ST_WB : ST_PREP;
					end else begin
						addr <= f_p ? calc : base;
						wb_val <= calc;
						wb_en <= !f_p || f_w;
						state <= ST_PREP;
					end
				end
				ST_PREP: begin
					state <= ST_ISSUE;
				end
				ST_ISSUE: begin
					mem_req_out <= 1'b1;
					mem_addr_out <= addr;
					mem_write_out <= !acc_load;
					mem_size_out <= size;
					if (size == `MTS_SZ_BYTE) begin
						mem_wdata_out <= {4{store_v[7:0]}};
					end else if (size == `MTS_SZ_HALF) begin
						mem_wdata_out <= {2{store_v[15:0]}};
					end else begin
						mem_wdata_out <= store_v;
					end
					state <= ST_WAIT;
				end
				ST_WAIT: begin
					if (mem_ack_in) begin
						mem_req_out <= 1'b0;
						if (acc_load && is_swap) begin
							load_hold <= ld_v;
						end else if (acc_load && (beat_reg == 4'hf)) begin
							pc <= ld_v;
							pc_loaded <= 1'b1;
						end
						if (is_swap && !beat) begin
							// Store follows at once; lock stays high between the two
							beat <= 1'b1;
							state <= ST_ISSUE;
						end else if (misc_dword && !beat) begin
							beat <= 1'b1;
							addr <= addr + `MTS_WORD_STEP;
							beat_reg <= f_rd | 4'h1;
							state <= ST_PREP;
						end else if (!last_beat) begin
							mask_left <= next_mask;
							addr <= addr + `MTS_WORD_STEP;
							beat_reg <= lowest_set(next_mask);
							state <= ST_PREP;
						end else begin
							mem_lock_out <= 1'b0;
							state <= ST_WB;
						end
					end
				end
				ST_WB: begin
					if (is_multi && f_l && f_s && instr[15]) begin
						csw <= ssw;
					end
					if (is_swap && (f_rd == 4'hf)) begin
						pc <= load_hold;
					end else if (!pc_loaded) begin
						pc <= pc + `MTS_WORD_STEP;
					end
					mem_user_out <= 1'b0;
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule // mts_exec
`default_nettype wire

// ===== tb/mts_exec_properties.sv
`default_nettype none
// ==========================================
// Port checker for the transfer block
module mts_exec_properties (
	// Clock, reset and host bus
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic hsel_in,
	input wire logic [7:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	// Memory link and traps
	input wire logic mem_req_out,
	input wire logic [31:0] mem_addr_out,
	input wire logic mem_write_out,
	input wire logic [1:0] mem_size_out,
	input wire logic [31:0] mem_wdata_out,
	input wire logic mem_user_out,
	input wire logic mem_lock_out,
	input wire logic mem_ack_in,
	input wire logic debug_override_in,
	input wire logic call_trap_out,
	input wire logic prefetch_abort_out,
	input wire logic debug_break_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] last_addr;
	logic [3:0] gap;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	// Last acked address and cycles since; saturates so idle spans never wrap
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			gap <= 4'hf;
		end else if (mem_req_out && mem_ack_in) begin
			last_addr <= mem_addr_out;
			gap <= 4'h0;
		end else if (gap != 4'hf) begin
			gap <= gap + 4'h1;
		end
	end
	// ==========================================
	// Sequences and properties
	sequence s_instr;
		hsel_in && htrans_in[1] && hready_in && hwrite_in && haddr_in == 8'h00 ##1 1'b1;
	endsequence
	sequence s_swap_load;
		mem_req_out && mem_lock_out && !mem_write_out && mem_ack_in;
	endsequence
	property p_call;
		s_instr ##0 hwdata_in[31:24] == 8'hef |-> ##[1:4] call_trap_out;
	endproperty
	property p_brk;
		s_instr ##0 (hwdata_in[27:20] == 8'h12 && hwdata_in[7:4] == 4'h7 && !debug_override_in)
			|-> ##[1:4] prefetch_abort_out;
	endproperty
	property p_dbg;
		s_instr ##0 (hwdata_in[27:20] == 8'h12 && hwdata_in[7:4] == 4'h7 && debug_override_in)
			|-> ##[1:4] debug_break_out;
	endproperty
	property p_one_trap;
		$onehot0({call_trap_out, prefetch_abort_out, debug_break_out});
	endproperty
	property p_swap;
		s_swap_load |=> (mem_lock_out && !mem_req_out) ##1
			(mem_lock_out && mem_req_out && mem_write_out && mem_addr_out == $past(mem_addr_out, 2));
	endproperty
	property p_unlock;
		mem_req_out && mem_lock_out && mem_write_out && mem_ack_in |=> !mem_lock_out && !mem_req_out;
	endproperty
	property p_hold;
		mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out) && $stable(mem_wdata_out)
			&& $stable(mem_write_out);
	endproperty
	property p_step;
		$rose(mem_req_out) && !mem_lock_out && gap < 4'h4 |-> mem_addr_out == last_addr + 32'h4;
	endproperty
	property p_user;
		mem_req_out && mem_user_out |-> mem_size_out != 2'b01 && !mem_lock_out;
	endproperty
	a_call: assert property (p_call) else $error("call trap missing");
	a_brk: assert property (p_brk) else $error("abort missing");
	a_dbg: assert property (p_dbg) else $error("debug break missing");
	a_one_trap: assert property (p_one_trap) else $error("two traps at once");
	a_swap: assert property (p_swap) else $error("exchange store wrong");
	a_unlock: assert property (p_unlock) else $error("lock held too long");
	a_hold: assert property (p_hold) else $error("request moved");
	a_step: assert property (p_step) else $error("beat address step");
	a_user: assert property (p_user) else $error("user access kind");
endmodule // mts_exec_properties
bind mts_exec mts_exec_properties u_props (.clk_sys_in, .resetn_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
	.hwdata_in, .hready_in, .mem_req_out, .mem_addr_out, .mem_write_out, .mem_size_out, .mem_wdata_out,
	.mem_user_out, .mem_lock_out, .mem_ack_in, .debug_override_in, .call_trap_out, .prefetch_abort_out,
	.debug_break_out);
`default_nettype wire

// ===== tb/mts_mem_model.sv
`default_nettype none
// ==========================================
// Memory system partner
module mts_mem_model (
	// Clock and request
	input wire logic clk_in,
	input wire logic req_in,
	input wire logic write_in,
	input wire logic [31:0] addr_in,
	input wire logic [1:0] size_in,
	input wire logic [31:0] wdata_in,
	// Answer
	output logic ack_out = 1'b0,
	output logic [31:0] rdata_out = 32'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [0:63];
	logic [31:0] lane;
	logic [1:0] wait_cnt = 2'h0;
	// Lanes a write touches; narrow data arrives replicated
	always_comb begin
		case (size_in)
			2'b00: lane = 32'hff << (8 * addr_in[1:0]);
			2'b01: lane = 32'hffff << (16 * addr_in[1]);
			default: lane = 32'hffff_ffff;
		endcase
	end
	// Answer after zero to three cycles; data lines scramble outside the answer
	always @(posedge clk_in) begin
		if (req_in && !ack_out && wait_cnt == 2'h0) begin
			ack_out <= 1'b1;
			rdata_out <= mem[addr_in[7:2]];
			if (write_in)
				mem[addr_in[7:2]] <= (mem[addr_in[7:2]] & ~lane) | (wdata_in & lane);
			wait_cnt <= 2'($urandom_range(3));
		end else begin
			ack_out <= 1'b0;
			rdata_out <= ~rdata_out;
			if (req_in && !ack_out)
				wait_cnt <= wait_cnt - 2'h1;
		end
	end
endmodule // mts_mem_model
`default_nettype wire

// ===== tb/mts_exec_bench.sv
`include "mts_regs.vh"
`default_nettype none
// ==========================================
// Bench for the transfer block
module mts_exec_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic dbg_ovr = 1'b0;
	logic hrdy, hresp, req, wr, usr, lck, ack, trp, pab, dbk;
	logic [31:0] hrdata, maddr, mwdata, mrdata, rd;
	logic [1:0] msize;
	logic [31:0] r [0:15];
	int n_fail = 0;
	int total_checks = 0;
	int n_user = 0;
	// 125 MHz clock
	always #4 clk_sys_in = ~clk_sys_in;
	mts_exec dut (.clk_sys_in, .resetn_in, .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hrdy), .hreadyout_out(hrdy),
		.hrdata_out(hrdata), .hresp_out(hresp), .mem_req_out(req), .mem_addr_out(maddr), .mem_write_out(wr),
		.mem_size_out(msize), .mem_wdata_out(mwdata), .mem_user_out(usr), .mem_lock_out(lck),
		.mem_ack_in(ack), .mem_rdata_in(mrdata), .debug_override_in(dbg_ovr), .call_trap_out(trp),
		.prefetch_abort_out(pab), .debug_break_out(dbk));
	mts_mem_model mem_i (.clk_in(clk_sys_in), .req_in(req), .write_in(wr), .addr_in(maddr), .size_in(msize),
		.wdata_in(mwdata), .ack_out(ack), .rdata_out(mrdata));
	// Count cycles spent on user-permission accesses
	always @(posedge clk_sys_in) begin
		if (req && usr)
			n_user++;
	end
	// ==========================================
	// Tasks and expectations
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One single transfer; entered just after a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		@(posedge clk_sys_in);
		while (hrdy !== 1'b1) @(posedge clk_sys_in);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clk_sys_in);
		while (hrdy !== 1'b1) @(posedge clk_sys_in);
		rd = hrdata;
	endtask
	task automatic setr(input logic [4:0] i, input logic [31:0] v);
		bus(1, `MTS_OFS_REG_INDEX, {27'h0, i});
		bus(1, `MTS_OFS_REG_DATA, v);
	endtask
	task automatic getr(input logic [4:0] i);
		bus(1, `MTS_OFS_REG_INDEX, {27'h0, i});
		bus(0, `MTS_OFS_REG_DATA, 0);
	endtask
	// Start an instruction, poll until idle; rd ends as the status word
	task automatic run(input logic [31:0] ins);
		bus(1, `MTS_OFS_INSTR, ins);
		rd = 1;
		for (int k = 0; k < 100 && rd[0] !== 1'b0; k++) bus(0, `MTS_OFS_STATUS, 0);
		chk({31'h0, rd[0]}, 32'h0);
	endtask
	function automatic logic [31:0] first(input logic p, input logic u, input int n);
		return u ? 32'h80 + {29'h0, p, 2'b0} : 32'h80 - 4 * n + (p ? 0 : 4);
	endfunction
	function automatic logic [31:0] ext(input logic [3:0] t, input logic [31:0] w, input logic [1:0] a);
		logic [15:0] h;
		logic [7:0] y;
		h = w >> (16 * a[1]);
		y = w >> (8 * a);
		return t == 4'hb ? {16'h0, h} : t == 4'hf ? {{16{h[15]}}, h} : {{24{y[7]}}, y};
	endfunction
	// Hangs are cut well beyond the expected run length
	initial begin
		#400us;
		n_fail++;
		stop_test();
	end
	// ==========================================
	// Main sequence
	initial begin
		logic [31:0] v, b;
		logic [15:0] m;
		logic [3:0] t;
		logic [7:0] o;
		int n;
		void'($urandom(32'h23fc9168));
		for (int i = 0; i < 64; i++) mem_i.mem[i] = $urandom;
		repeat (16) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		@(posedge clk_sys_in);
		bus(0, `MTS_OFS_CUR_STATUS, 0);
		chk(rd, `MTS_RST_CUR_STATUS);
		chk({31'h0, hresp}, 32'h0);
		bus(1, 8'h1c, $urandom);
		bus(0, 8'h1c, 0);
		chk(rd, 32'h0);
		for (int i = 0; i < 15; i++) begin
			r[i] = $urandom;
			setr(i, r[i]);
		end
		// Traps with random immediates, then a failing condition
		for (int k = 0; k < 3; k++) begin
			dbg_ovr <= k[0];
			run(k == 0 ? {8'hef, 24'($urandom)} : {12'he12, 12'($urandom), 4'h7, 4'($urandom)});
			chk(rd, k == 0 ? 32'h2 : k == 1 ? 32'h8 : 32'h4);
		end
		run(32'h088d_00ff);
		chk(rd, 32'h20);
		// Four addressing modes, stores then loads, with writeback
		for (int k = 0; k < 8; k++) begin
			m = 16'($urandom_range(255, 1));
			n = $countones(m);
			if (k == 4)
				for (int i = 0; i < 64; i++) mem_i.mem[i] = $urandom;
			setr(13, 32'h80);
			run({4'he, 3'b100, k[1], k[0], 2'b01, k[2], 4'hd, m});
			b = first(k[1], k[0], n);
			for (int i = 0; i < 8; i++) begin
				if (m[i]) begin
					if (k[2])
						getr(i);
					chk(k[2] ? rd : mem_i.mem[b[7:2]], k[2] ? mem_i.mem[b[7:2]] : r[i]);
					r[i] = mem_i.mem[b[7:2]];
					b += 4;
				end
			end
			getr(13);
			chk(rd, k[0] ? 32'h80 + 4 * n : 32'h80 - 4 * n);
		end
		// User bank store, then status restore on a load of the PC
		bus(1, `MTS_OFS_SAVED_STATUS, 32'ha000_00d3);
		v = $urandom;
		setr(5'h18, v);
		setr(13, 32'h40);
		run(32'he8cd_0100);
		chk(mem_i.mem[16], v);
		mem_i.mem[17] = 32'h20;
		setr(13, 32'h44);
		run(32'he8dd_8000);
		bus(0, `MTS_OFS_CUR_STATUS, 0);
		chk(rd, 32'ha000_00d3);
		bus(0, `MTS_OFS_PROG_COUNTER, 0);
		chk(rd, 32'h20);
		// Word exchange with one register, then byte exchange
		v = $urandom;
		setr(1, v);
		setr(2, 32'h60);
		b = mem_i.mem[24];
		run(32'he102_1091);
		getr(1);
		chk(rd, b);
		chk(mem_i.mem[24], v);
		setr(2, 32'h61);
		setr(4, r[4]);
		run(32'he142_3094);
		getr(3);
		chk(rd, {24'h0, v[15:8]});
		chk(mem_i.mem[24], {v[31:16], r[4][7:0], v[7:0]});
		// Narrow loads relative to the PC
		for (int k = 0; k < 6; k++) begin
			t = k % 3 == 0 ? 4'hb : k % 3 == 1 ? 4'hd : 4'hf;
			o = 8'($urandom_range(46)) & (t == 4'hd ? 8'hff : 8'hfe);
			bus(1, `MTS_OFS_PROG_COUNTER, 32'h40);
			run({12'he1d, 8'hf5, o[7:4], t, o[3:0]});
			getr(5);
			chk(rd, ext(t, mem_i.mem[(8'h48 + o) >> 2], o[1:0]));
		end
		// Doubleword pair, post-indexed register offset, user permissions
		setr(9, 32'h88);
		run(32'he1c9_40d0);
		getr(4);
		chk(rd, mem_i.mem[34]);
		getr(5);
		chk(rd, mem_i.mem[35]);
		run(32'he1c9_60f0);
		chk(mem_i.mem[35], r[7]);
		setr(1, 32'h90);
		v = 32'($urandom_range(3)) << 2;
		setr(2, v);
		run(32'he691_0002);
		getr(0);
		chk(rd, mem_i.mem[36]);
		getr(1);
		chk(rd, 32'h90 + v);
		b = 32'h90 + v;
		for (int k = 0; k < 2; k++) begin
			n = n_user;
			run(k ? 32'he591_0000 : 32'he4b1_0000);
			getr(0);
			chk(rd, mem_i.mem[b[7:2]]);
			chk({31'h0, n_user != n}, {31'h0, !k[0]});
		end
		stop_test();
	end
endmodule // mts_exec_bench
`default_nettype wire
